// ---- hdl/cioc_pkg.sv ----
// shared constants and types for the core interrupt and option block
package cioc_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTL_B0  = 10'h00b;
   localparam logic [9:0] IDX_CTL_B1  = 10'h08b;
   localparam logic [9:0] IDX_CTL_B2  = 10'h10b;
   localparam logic [9:0] IDX_CTL_B3  = 10'h18b;
   localparam logic [9:0] IDX_OPT_B1  = 10'h081;
   localparam logic [9:0] IDX_OPT_B3  = 10'h181;
   localparam logic [9:0] IDX_PEN     = 10'h08c;
   localparam logic [9:0] IDX_STAT    = 10'h1f0;
   localparam logic [9:0] IDX_MASK    = 10'h1f1;
   // interrupt_control field positions
   localparam int CTL_GLOBAL = 7;
   localparam int CTL_PERIPH = 6;
   localparam int CTL_T0IE = 5;
   localparam int CTL_EXIE = 4;
   localparam int CTL_PCIE = 3;
   localparam int CTL_T0IF = 2;
   localparam int CTL_EXIF = 1;
   localparam int CTL_PCIF = 0;
   // timer_option_control field positions
   localparam int OPT_PUD  = 7;
   localparam int OPT_EDG  = 6;
   localparam int OPT_TCS  = 5;
   localparam int OPT_TSE  = 4;
   localparam int OPT_ASSIGN = 3;
   localparam int OPT_PS_H = 2;
   // event status bit positions
   localparam int EV_T0 = 0;
   localparam int EV_EX = 1;
   localparam int EV_PC = 2;
   // reset values
   localparam logic [7:0] CTL_RESET  = 8'h00;
   localparam logic [7:0] OPT_RESET  = 8'hff;
   localparam logic [7:0] PEN_RESET  = 8'h00;
   localparam logic [2:0] STAT_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      CIOC_SEL_NONE = 3'b000,
      CIOC_SEL_CTL  = 3'b001,
      CIOC_SEL_OPT  = 3'b010,
      CIOC_SEL_PEN  = 3'b011,
      CIOC_SEL_STAT = 3'b100,
      CIOC_SEL_MASK = 3'b101
   } cioc_sel_t;
endpackage

// ---- hdl/cioc_core_irq.sv ----
// core interrupt control, option register and axi4-lite slave
// Summary of operation
// - The control register keeps an enable and a flag for timer0 overflow, port change and the external pin.
// - The control register is one 8-bit read/write store reached at four bank aliases.
// - Each flag is set by its event whatever its own enable and the global enable say.
// - Peripheral requests reach the core only while the peripheral master enable is set.
// - A separate enable register masks each peripheral request before the master enable.
// - The option register is one 8-bit store reached at two bank aliases.
// - Timer0 runs undivided only while the prescaler is given to the watchdog.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module cioc_core_irq (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // interrupt sources
   input  wire logic        timer0_overflow,
   input  wire logic        external_irq_pin,
   input  wire logic [7:4]  port_b_a,
   input  wire logic        port_b_read,
   input  wire logic [7:0]  peripheral_flags,
   // requests
   output logic             core_irq_req,
   output logic             irq,
   // option controls
   output logic             pullup_disable,
   output logic             ext_edge_select,
   output logic             timer0_clock_select,
   output logic             timer0_edge_select,
   output logic             prescaler_assign,
   output logic [2:0]       prescaler_rate,
   output logic             timer0_prescale_bypass
);

   function automatic cioc_pkg::cioc_sel_t decode(input logic [11:0] a);
      logic [9:0] idx;
      idx = a[11:2];
      if (idx == cioc_pkg::IDX_CTL_B0 || idx == cioc_pkg::IDX_CTL_B1 ||
          idx == cioc_pkg::IDX_CTL_B2 || idx == cioc_pkg::IDX_CTL_B3) begin
         decode = cioc_pkg::CIOC_SEL_CTL;
      end else if (idx == cioc_pkg::IDX_OPT_B1 ||
                   idx == cioc_pkg::IDX_OPT_B3) begin
         decode = cioc_pkg::CIOC_SEL_OPT;
      end else if (idx == cioc_pkg::IDX_PEN) begin
         decode = cioc_pkg::CIOC_SEL_PEN;
      end else if (idx == cioc_pkg::IDX_STAT) begin
         decode = cioc_pkg::CIOC_SEL_STAT;
      end else if (idx == cioc_pkg::IDX_MASK) begin
         decode = cioc_pkg::CIOC_SEL_MASK;
      end else begin
         decode = cioc_pkg::CIOC_SEL_NONE;
      end
   endfunction

   logic [7:0]  interrupt_control;
   logic [7:0]  timer_option_control;
   logic [7:0]  peripheral_enable_reg;
   logic [2:0]  irq_status;
   logic [2:0]  irq_mask;
   logic [11:0] aw_addr;
   logic        aw_held;
   logic [7:0]  w_data;
   logic        w_byte0;
   logic        w_held;
   logic        ext_prev;
   logic [7:4]  port_latch;
   logic        port_primed;
   logic        mismatch_prev;
   logic        wr_fire;
   logic        rd_fire;
   logic        ext_edge;
   logic        mismatch;
   logic [2:0]  hw_event;
   logic [7:0]  next_ctl;
   logic        next_req;
   cioc_pkg::cioc_sel_t wr_sel;
   cioc_pkg::cioc_sel_t rd_sel;

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wr_sel  = decode(aw_addr);
   assign rd_sel  = decode(s_axi_araddr);

   // write address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= 12'h000;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_held       <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held       <= 1'b0;
         w_data       <= 8'h00;
         w_byte0      <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held       <= 1'b1;
         w_data       <= s_axi_wdata[7:0];
         w_byte0      <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_held       <= 1'b0;
      end else begin
         s_axi_wready <= !w_held;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= cioc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_sel == cioc_pkg::CIOC_SEL_NONE) ?
                         cioc_pkg::RESP_SLVERR : cioc_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // event detection; the pin is taken as synchronous already
   assign ext_edge = timer_option_control[cioc_pkg::OPT_EDG] ?
                     (external_irq_pin && !ext_prev) :
                     (!external_irq_pin && ext_prev);
   assign mismatch = port_primed && (port_b_a != port_latch);
   assign hw_event = {mismatch && !mismatch_prev, ext_edge, timer0_overflow};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // track the pin in reset so a high pin gives no false edge
         ext_prev      <= external_irq_pin;
         port_latch    <= 4'h0;
         port_primed   <= 1'b0;
         mismatch_prev <= 1'b0;
      end else begin
         ext_prev      <= external_irq_pin;
         mismatch_prev <= mismatch;
         // first sample after reset seeds the latch, not a reset value
         if (!port_primed || port_b_read) begin
            port_latch  <= port_b_a;
            port_primed <= 1'b1;
         end
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_comb begin
      next_ctl = interrupt_control;
      if (wr_fire && w_byte0 && wr_sel == cioc_pkg::CIOC_SEL_CTL) begin
         next_ctl = w_data;
      end
      next_ctl[cioc_pkg::CTL_T0IF] = next_ctl[cioc_pkg::CTL_T0IF] |
                                     timer0_overflow;
      next_ctl[cioc_pkg::CTL_EXIF] = next_ctl[cioc_pkg::CTL_EXIF] |
                                     ext_edge;
      // flag stays set while the mismatch lasts
      next_ctl[cioc_pkg::CTL_PCIF] = next_ctl[cioc_pkg::CTL_PCIF] |
                                     mismatch;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interrupt_control <= cioc_pkg::CTL_RESET;
      end else begin
         interrupt_control <= next_ctl;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_option_control  <= cioc_pkg::OPT_RESET;
         peripheral_enable_reg <= cioc_pkg::PEN_RESET;
         irq_mask              <= cioc_pkg::MASK_RESET;
      end else if (wr_fire && w_byte0) begin
         if (wr_sel == cioc_pkg::CIOC_SEL_OPT) begin
            timer_option_control <= w_data;
         end
         if (wr_sel == cioc_pkg::CIOC_SEL_PEN) begin
            peripheral_enable_reg <= w_data;
         end
         if (wr_sel == cioc_pkg::CIOC_SEL_MASK) begin
            irq_mask <= w_data[2:0];
         end
      end
   end

   // sticky status, cleared by reading it; new events survive the read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= cioc_pkg::STAT_RESET;
      end else if (rd_fire && rd_sel == cioc_pkg::CIOC_SEL_STAT) begin
         irq_status <= hw_event;
      end else begin
         irq_status <= irq_status | hw_event;
      end
   end

   // read channel, one request at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= cioc_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= cioc_pkg::RESP_OKAY;
         case (rd_sel)
            cioc_pkg::CIOC_SEL_CTL:
               s_axi_rdata <= {24'h00_0000, interrupt_control};
            cioc_pkg::CIOC_SEL_OPT:
               s_axi_rdata <= {24'h00_0000, timer_option_control};
            cioc_pkg::CIOC_SEL_PEN:
               s_axi_rdata <= {24'h00_0000, peripheral_enable_reg};
            cioc_pkg::CIOC_SEL_STAT:
               s_axi_rdata <= {29'h0000_0000, irq_status};
            cioc_pkg::CIOC_SEL_MASK:
               s_axi_rdata <= {29'h0000_0000, irq_mask};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= cioc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // request to the core, registered so the output is glitch free
   always_comb begin
      next_req = (interrupt_control[cioc_pkg::CTL_T0IE] &
                  interrupt_control[cioc_pkg::CTL_T0IF]) |
                 (interrupt_control[cioc_pkg::CTL_EXIE] &
                  interrupt_control[cioc_pkg::CTL_EXIF]) |
                 (interrupt_control[cioc_pkg::CTL_PCIE] &
                  interrupt_control[cioc_pkg::CTL_PCIF]);
      next_req = interrupt_control[cioc_pkg::CTL_GLOBAL] & (next_req |
                 (interrupt_control[cioc_pkg::CTL_PERIPH] &
                  |(peripheral_enable_reg & peripheral_flags)));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_irq_req <= 1'b0;
         irq          <= 1'b0;
      end else begin
         core_irq_req <= next_req;
         irq          <= |(irq_status & irq_mask);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pullup_disable         <= cioc_pkg::OPT_RESET[cioc_pkg::OPT_PUD];
         ext_edge_select        <= cioc_pkg::OPT_RESET[cioc_pkg::OPT_EDG];
         timer0_clock_select    <= cioc_pkg::OPT_RESET[cioc_pkg::OPT_TCS];
         timer0_edge_select     <= cioc_pkg::OPT_RESET[cioc_pkg::OPT_TSE];
         prescaler_assign       <= cioc_pkg::OPT_RESET[cioc_pkg::OPT_ASSIGN];
         prescaler_rate         <= cioc_pkg::OPT_RESET[2:0];
         timer0_prescale_bypass <= cioc_pkg::OPT_RESET[cioc_pkg::OPT_ASSIGN];
      end else begin
         pullup_disable      <= timer_option_control[cioc_pkg::OPT_PUD];
         ext_edge_select     <= timer_option_control[cioc_pkg::OPT_EDG];
         timer0_clock_select <= timer_option_control[cioc_pkg::OPT_TCS];
         timer0_edge_select  <= timer_option_control[cioc_pkg::OPT_TSE];
         prescaler_assign    <= timer_option_control[cioc_pkg::OPT_ASSIGN];
         prescaler_rate      <= timer_option_control[cioc_pkg::OPT_PS_H:0];
         // watchdog owns the prescaler, so timer0 sees no division
         timer0_prescale_bypass <=
            timer_option_control[cioc_pkg::OPT_ASSIGN];
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ctl_write(logic [9:0] idx);
      wr_fire && w_byte0 && aw_addr[11:2] == idx;
   endsequence

   sequence s_opt_write(logic [9:0] idx);
      wr_fire && w_byte0 && aw_addr[11:2] == idx;
   endsequence

   a_t0_flag_set: assert property (timer0_overflow |=>
      interrupt_control[cioc_pkg::CTL_T0IF])
      else $error("timer0 flag not set by overflow");

   a_ext_flag_set: assert property (ext_edge |=>
      interrupt_control[cioc_pkg::CTL_EXIF])
      else $error("external flag not set by edge");

   a_ctl_alias_top: assert property (
      s_ctl_write(cioc_pkg::IDX_CTL_B3) |=>
      (interrupt_control[7:3] == $past(w_data[7:3])))
      else $error("control alias write lost");

   a_opt_alias_top: assert property (
      s_opt_write(cioc_pkg::IDX_OPT_B3) |-> ##2
      (prescaler_rate == $past(w_data[2:0], 2)))
      else $error("option alias write lost");

   a_global_blocks_req: assert property (
      !interrupt_control[cioc_pkg::CTL_GLOBAL] |=> !core_irq_req)
      else $error("request without global enable");

   a_t0_raises_req: assert property (
      interrupt_control[cioc_pkg::CTL_GLOBAL] &&
      interrupt_control[cioc_pkg::CTL_T0IE] &&
      interrupt_control[cioc_pkg::CTL_T0IF] |=> core_irq_req)
      else $error("enabled timer0 flag gave no request");

   a_master_gates_req: assert property (
      !interrupt_control[cioc_pkg::CTL_PERIPH] &&
      (interrupt_control[5:3] & interrupt_control[2:0]) == 3'h0
      |=> !core_irq_req)
      else $error("peripheral request without master enable");

   a_pen_masks_req: assert property (
      peripheral_enable_reg == 8'h00 &&
      (interrupt_control[5:3] & interrupt_control[2:0]) == 3'h0
      |=> !core_irq_req)
      else $error("masked peripheral reached core");

   a_bypass_follows: assert property (
      ##1 timer0_prescale_bypass ==
      $past(timer_option_control[cioc_pkg::OPT_ASSIGN]))
      else $error("bypass does not follow assignment");

   a_bvalid_holds: assert property (
      s_axi_bvalid |=> s_axi_bvalid || $past(s_axi_bready))
      else $error("write response dropped early");

   a_write_answers: assert property (
      wr_fire |=> s_axi_bvalid)
      else $error("write gave no response");

endmodule

// ---- sim/cioc_src_model.sv ----
// model of the timer, pin, port and peripheral request sources
`timescale 1ns/1ps
module cioc_src_model (
   // clock and command from the bench
   input  wire logic       aclk,
   input  wire logic [2:0] cmd,
   input  wire logic [7:0] pf_in,
   // source outputs
   output logic            timer0_overflow,
   output logic            external_irq_pin,
   output logic [7:4]      port_b_a,
   output logic            port_b_read,
   output logic [7:0]      peripheral_flags
);
   initial begin
      external_irq_pin = 1'b0;
      port_b_a         = 4'h0;
   end
   // events are one-cycle pulses, pins hold as levels
   always @(posedge aclk) begin
      timer0_overflow  <= (cmd == 3'h1);
      port_b_read      <= (cmd == 3'h4);
      peripheral_flags <= pf_in;
      if (cmd == 3'h2)
         external_irq_pin <= ~external_irq_pin;
      if (cmd == 3'h3)
         port_b_a <= port_b_a ^ 4'h1;
   end
endmodule

// ---- sim/cioc_core_irq_bench.sv ----
// self-checking bench for the core interrupt and option block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module cioc_core_irq_bench;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        timer0_overflow, external_irq_pin, port_b_read;
   logic [7:4]  port_b_a;
   logic [7:0]  peripheral_flags, pf_in, c, pe, pf, op;
   logic        core_irq_req, irq, pullup_disable, ext_edge_select;
   logic        timer0_clock_select, timer0_edge_select, prescaler_assign;
   logic [2:0]  prescaler_rate, cmd;
   logic        timer0_prescale_bypass;
   logic [9:0]  ctl_idx [4];
   int          error_cnt, compares;
   cioc_core_irq u_cioc_core_irq (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .timer0_overflow, .external_irq_pin, .port_b_a, .port_b_read,
      .peripheral_flags, .core_irq_req, .irq, .pullup_disable,
      .ext_edge_select, .timer0_clock_select, .timer0_edge_select,
      .prescaler_assign, .prescaler_rate, .timer0_prescale_bypass);
   cioc_src_model u_cioc_src_model (.aclk, .cmd, .pf_in, .timer0_overflow,
      .external_irq_pin, .port_b_a, .port_b_read, .peripheral_flags);
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   function automatic logic [11:0] ba(input logic [9:0] i);
      return {i, 2'b00};
   endfunction
   // global enable gates all; master enable gates peripheral requests
   function automatic logic irq_exp(input logic [7:0] k, e, f);
      return k[7] & ((k[5] & k[2]) | (k[4] & k[1]) | (k[3] & k[0])
                     | (k[6] & (|(e & f))));
   endfunction
   task automatic axw(input logic [11:0] a, input logic [31:0] v);
      bit ad, dd, dn;
      ad = 0;
      dd = 0;
      dn = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64 && !dn; n++) begin
         @(posedge aclk);
         if (ad && dd && s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            dn = 1;
         end
         if (!ad && s_axi_awready) begin
            ad = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!dd && s_axi_wready) begin
            dd = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      if (!dn) begin
         error_cnt++;
         finish_test();
      end
   endtask
   task automatic axr(input logic [11:0] a);
      bit ad, dn;
      ad = 0;
      dn = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64 && !dn; n++) begin
         @(posedge aclk);
         if (ad && s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            dn = 1;
         end
         if (!ad && s_axi_arready) begin
            ad = 1;
            s_axi_arvalid <= 1'b0;
         end
      end
      if (!dn) begin
         error_cnt++;
         finish_test();
      end
   endtask
   task automatic rdc(input logic [9:0] i, input logic [7:0] e, string nm);
      axr(ba(i));
      `CHK(nm, {24'h0, e}, d)
      `CHK("rresp", cioc_pkg::RESP_OKAY, r)
   endtask
   task automatic ev(input logic [2:0] k);
      cmd <= k;
      @(posedge aclk);
      cmd <= 3'h0;
      // registered irq lands one edge after the status bit
      repeat (3) @(posedge aclk);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      cmd = 3'h0;
      pf_in = 8'h00;
      ctl_idx = '{cioc_pkg::IDX_CTL_B0, cioc_pkg::IDX_CTL_B1,
                  cioc_pkg::IDX_CTL_B2, cioc_pkg::IDX_CTL_B3};
      void'($urandom(32'h98e21279));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK("bypass", 1'b1, timer0_prescale_bypass)
      rdc(cioc_pkg::IDX_CTL_B0, cioc_pkg::CTL_RESET, "ctl reset");
      rdc(cioc_pkg::IDX_OPT_B1, cioc_pkg::OPT_RESET, "opt reset");
      rdc(cioc_pkg::IDX_PEN, cioc_pkg::PEN_RESET, "pen reset");
      rdc(cioc_pkg::IDX_MASK, 8'h00, "mask reset");
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         c = 8'($urandom);
         axw(ba(ctl_idx[i]), {24'h0, c});
         `CHK("bresp", cioc_pkg::RESP_OKAY, r)
         for (int j = 0; j < 4; j++)
            rdc(ctl_idx[j], c, "ctl alias");
         c = 8'($urandom);
         axw(ba(i[0] ? cioc_pkg::IDX_OPT_B1 : cioc_pkg::IDX_OPT_B3),
             {24'h0, c});
         rdc(i[0] ? cioc_pkg::IDX_OPT_B3 : cioc_pkg::IDX_OPT_B1, c, "opt");
         op = {pullup_disable, ext_edge_select, timer0_clock_select,
               timer0_edge_select, prescaler_assign, prescaler_rate};
         `CHK("opt pins", c, op)
         `CHK("bypass", c[3], timer0_prescale_bypass)
      end
      $display("test aliases done");
      axw(ba(cioc_pkg::IDX_OPT_B1), 32'hff);
      // flags cleared before any enable, no stale request
      axw(ba(cioc_pkg::IDX_CTL_B1), 32'h0);
      for (int k = 1; k < 4; k++)
         ev(3'(k));
      rdc(cioc_pkg::IDX_CTL_B2, 8'h07, "flags");
      `CHK("core req", 1'b0, core_irq_req)
      ev(3'h4);
      axw(ba(cioc_pkg::IDX_CTL_B0), 32'h0);
      rdc(cioc_pkg::IDX_CTL_B0, 8'h00, "flags clear");
      rdc(cioc_pkg::IDX_STAT, 8'h07, "status");
      rdc(cioc_pkg::IDX_STAT, 8'h00, "status clear");
      `CHK("irq masked", 1'b0, irq)
      $display("test events done");
      axw(ba(cioc_pkg::IDX_MASK), 32'h1);
      ev(3'h1);
      `CHK("irq", 1'b1, irq)
      axw(ba(cioc_pkg::IDX_MASK), 32'h0);
      repeat (3) @(posedge aclk);
      `CHK("irq off", 1'b0, irq)
      axw(ba(cioc_pkg::IDX_MASK), 32'h1);
      repeat (3) @(posedge aclk);
      `CHK("irq on", 1'b1, irq)
      rdc(cioc_pkg::IDX_STAT, 8'h01, "status t0");
      repeat (3) @(posedge aclk);
      `CHK("irq cleared", 1'b0, irq)
      $display("test irq done");
      for (int i = 0; i < 16; i++) begin
         c = 8'($urandom);
         pe = 8'($urandom);
         pf = 8'($urandom);
         if (i < 2)
            {c[7:3], c[2:0], pe, pf} = {2'b11, i[0], 5'h0, 8'hff, 8'hff};
         if (!c[7])
            c[6] = 1'b0;
         pf_in <= pf;
         axw(ba(cioc_pkg::IDX_PEN), {24'h0, pe});
         axw(ba(cioc_pkg::IDX_CTL_B3), {24'h0, c});
         repeat (3) @(posedge aclk);
         `CHK("req", irq_exp(c, pe, pf), core_irq_req)
      end
      $display("test request done");
      // falling edge mode, then a write whose low byte strobe is off
      axw(ba(cioc_pkg::IDX_OPT_B1), 32'hbf);
      axw(ba(cioc_pkg::IDX_CTL_B0), 32'h0);
      ev(3'h2);
      rdc(cioc_pkg::IDX_CTL_B0, 8'h02, "falling edge");
      s_axi_wstrb <= 4'h0;
      axw(ba(cioc_pkg::IDX_CTL_B0), 32'hff);
      s_axi_wstrb <= 4'hf;
      `CHK("bresp", cioc_pkg::RESP_OKAY, r)
      rdc(cioc_pkg::IDX_CTL_B0, 8'h02, "strobe off");
      $display("test edge done");
      axw(12'h000, 32'h5a);
      `CHK("bresp", cioc_pkg::RESP_SLVERR, r)
      axr(12'h000);
      `CHK("rdata", 32'h0, d)
      `CHK("rresp", cioc_pkg::RESP_SLVERR, r)
      $display("test unmapped done");
      finish_test();
   end
endmodule
